// ==== status_indicator_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_indicator_logic (
  input  wire logic                                       CLK_SYS,
  input  wire logic                                       RESET,
  input  wire logic [status_indicator_pkg::ADDR_WIDTH-1:0] ADDR,
  input  wire logic [status_indicator_pkg::DATA_WIDTH-1:0] WDATA,
  input  wire logic                                       WR,
  input  wire logic                                       RD,
  output logic      [status_indicator_pkg::DATA_WIDTH-1:0] RDATA,
  output logic                                            IRQ,
  input  wire status_indicator_pkg::alu_request_type       ALU_REQ,
  output logic      [status_indicator_pkg::OPND_WIDTH-1:0] ALU_RESULT,
  output logic                                            ALU_DONE,
  input  wire status_indicator_pkg::io_completion_type     IO_DONE,
  input  wire status_indicator_pkg::interrupt_accept_type  INT_ACCEPT,
  input  wire logic [15:0]                                PSW_SET,
  input  wire status_indicator_pkg::register_select_type   REG_SELECT,
  output logic      [7:0]                                 REG_ENABLE,
  output logic      [15:0]                                LEVEL_STATUS,
  output logic      [15:0]                                PROC_STATUS
);

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic and sign carries

  logic [31:0] width_mask;
  logic [31:0] opnd_a;
  logic [31:0] opnd_b;
  logic [32:0] sum;
  logic [31:0] result;
  logic        carry_into_sign;
  logic        carry_out_sign;
  logic        sign_bit;
  logic        next_carry;
  logic        next_overflow;

  always_comb begin
    unique case (ALU_REQ.width)
      status_indicator_pkg::WIDTH_BYTE: begin
        width_mask = 32'h000000FF;
      end
      status_indicator_pkg::WIDTH_WORD: begin
        width_mask = 32'h0000FFFF;
      end
      status_indicator_pkg::WIDTH_DOUBLE: begin
        width_mask = 32'hFFFFFFFF;
      end
      default: begin
        width_mask = 32'h0000FFFF;
      end
    endcase
  end

  always_comb begin
    opnd_a = ALU_REQ.operand_a & width_mask;
    if (ALU_REQ.subtract) begin
      opnd_b = ~ALU_REQ.operand_b & width_mask; // R03
    end else begin
      opnd_b = ALU_REQ.operand_b & width_mask;
    end
    sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {32'h00000000, ALU_REQ.subtract}; // R03
    result = sum[31:0] & width_mask;
  end

  // Sign position follows the operand width; carry out is the bit just above it
  always_comb begin
    unique case (ALU_REQ.width)
      status_indicator_pkg::WIDTH_BYTE: begin
        sign_bit        = sum[status_indicator_pkg::SIGN_BYTE]; // R14
        carry_out_sign  = sum[status_indicator_pkg::SIGN_BYTE+1];
        carry_into_sign = sum[status_indicator_pkg::SIGN_BYTE]
                          ^ opnd_a[status_indicator_pkg::SIGN_BYTE]
                          ^ opnd_b[status_indicator_pkg::SIGN_BYTE];
      end
      status_indicator_pkg::WIDTH_DOUBLE: begin
        sign_bit        = sum[status_indicator_pkg::SIGN_DOUBLE]; // R14
        carry_out_sign  = sum[status_indicator_pkg::SIGN_DOUBLE+1];
        carry_into_sign = sum[status_indicator_pkg::SIGN_DOUBLE]
                          ^ opnd_a[status_indicator_pkg::SIGN_DOUBLE]
                          ^ opnd_b[status_indicator_pkg::SIGN_DOUBLE];
      end
      default: begin
        sign_bit        = sum[status_indicator_pkg::SIGN_WORD]; // R14
        carry_out_sign  = sum[status_indicator_pkg::SIGN_WORD+1];
        carry_into_sign = sum[status_indicator_pkg::SIGN_WORD]
                          ^ opnd_a[status_indicator_pkg::SIGN_WORD]
                          ^ opnd_b[status_indicator_pkg::SIGN_WORD];
      end
    endcase
    next_overflow = carry_into_sign ^ carry_out_sign; // R01 R02
    next_carry    = carry_out_sign ^ ALU_REQ.subtract; // R04
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ALU_RESULT <= 32'h00000000;
      ALU_DONE   <= 1'b0;
    end else begin
      ALU_DONE <= ALU_REQ.valid;
      if (ALU_REQ.valid) begin
        ALU_RESULT <= result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode

  logic wr_lsr;
  logic wr_psw;
  logic wr_irq_status;
  logic wr_irq_mask;

  always_comb begin
    wr_lsr        = WR && (ADDR == status_indicator_pkg::ADDR_LEVEL_STATUS);
    wr_psw        = WR && (ADDR == status_indicator_pkg::ADDR_PROC_STATUS);
    wr_irq_status = WR && (ADDR == status_indicator_pkg::ADDR_IRQ_STATUS);
    wr_irq_mask   = WR && (ADDR == status_indicator_pkg::ADDR_IRQ_MASK);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Level status register

  logic [15:0] next_lsr;

  // Hardware updates win over a software write in the same cycle
  always_comb begin
    next_lsr = LEVEL_STATUS;
    if (wr_lsr) begin
      next_lsr = WDATA;
    end
    if (ALU_REQ.valid) begin
      next_lsr[status_indicator_pkg::LSR_EVEN]     = ~result[0];
      next_lsr[status_indicator_pkg::LSR_CARRY]    = next_carry;
      next_lsr[status_indicator_pkg::LSR_OVERFLOW] = next_overflow; // R01 R02
      next_lsr[status_indicator_pkg::LSR_NEGATIVE] = sign_bit;
      next_lsr[status_indicator_pkg::LSR_ZERO]     = (result == 32'h00000000);
    end else if (IO_DONE.valid) begin
      next_lsr[status_indicator_pkg::LSR_EVEN]     = IO_DONE.condition_code[2]; // R05 R06
      next_lsr[status_indicator_pkg::LSR_CARRY]    = IO_DONE.condition_code[1];
      next_lsr[status_indicator_pkg::LSR_OVERFLOW] = IO_DONE.condition_code[0];
    end else if (INT_ACCEPT.valid) begin
      next_lsr[status_indicator_pkg::LSR_EVEN]     = INT_ACCEPT.condition_code[2]; // R07
      next_lsr[status_indicator_pkg::LSR_CARRY]    = INT_ACCEPT.condition_code[1];
      next_lsr[status_indicator_pkg::LSR_OVERFLOW] = INT_ACCEPT.condition_code[0];
    end
    next_lsr = next_lsr & status_indicator_pkg::LSR_IMPL_MASK; // R12
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      LEVEL_STATUS <= status_indicator_pkg::LSR_RESET;
    end else begin
      LEVEL_STATUS <= next_lsr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Condition code record

  logic [2:0]                          last_cc;
  status_indicator_pkg::cc_source_type last_source;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      last_cc     <= 3'h0;
      last_source <= status_indicator_pkg::CC_SOURCE_NONE;
    end else if (IO_DONE.valid) begin
      last_cc     <= IO_DONE.condition_code; // R06
      last_source <= status_indicator_pkg::CC_SOURCE_IO;
    end else if (INT_ACCEPT.valid) begin
      last_cc     <= INT_ACCEPT.condition_code; // R07
      last_source <= status_indicator_pkg::CC_SOURCE_INTERRUPT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor status word: sticky checks, write one to clear

  logic [15:0] psw_set_masked;

  always_comb begin
    psw_set_masked = PSW_SET & status_indicator_pkg::PSW_IMPL_MASK; // R13
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PROC_STATUS <= status_indicator_pkg::PSW_RESET;
    end else if (wr_psw) begin
      PROC_STATUS <= (PROC_STATUS & ~WDATA) | psw_set_masked; // R13
    end else begin
      PROC_STATUS <= PROC_STATUS | psw_set_masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status bytes

  logic [7:0] status_byte_direct;
  logic [7:0] status_byte_cycle;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      status_byte_direct <= status_indicator_pkg::BYTE_RESET;
      status_byte_cycle  <= status_indicator_pkg::BYTE_RESET;
    end else if (INT_ACCEPT.valid) begin
      if (INT_ACCEPT.cycle_steal) begin
        status_byte_cycle <= INT_ACCEPT.status_byte; // R10 R11
        status_byte_cycle[status_indicator_pkg::BYTE_CS_ZERO_BIT] <= 1'b0; // R11
      end else begin
        status_byte_direct <= INT_ACCEPT.status_byte; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General register select

  logic sel_high;

  always_comb begin
    if (REG_SELECT.two_bit) begin
      sel_high = 1'b0; // R09
    end else begin
      sel_high = REG_SELECT.field[2];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_select
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          REG_ENABLE[g] <= 1'b0;
        end else begin
          REG_ENABLE[g] <= REG_SELECT.valid
                           && ({sel_high, REG_SELECT.field[1:0]} == 3'(g)); // R08 R09
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [status_indicator_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [status_indicator_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [status_indicator_pkg::IRQ_WIDTH-1:0] irq_event;
  logic [status_indicator_pkg::IRQ_WIDTH-1:0] next_irq_status;

  always_comb begin
    irq_event = '0;
    irq_event[status_indicator_pkg::IRQ_OVERFLOW]   = ALU_REQ.valid && next_overflow;
    irq_event[status_indicator_pkg::IRQ_IO_DONE]    = IO_DONE.valid;
    irq_event[status_indicator_pkg::IRQ_IO_FAIL]    =
      IO_DONE.valid && (IO_DONE.condition_code != status_indicator_pkg::CC_SATISFACTORY);
    irq_event[status_indicator_pkg::IRQ_INT_ACCEPT] = INT_ACCEPT.valid;
    irq_event[status_indicator_pkg::IRQ_PSW_CHECK]  = |psw_set_masked;
    next_irq_status = irq_status;
    if (wr_irq_status) begin
      next_irq_status = irq_status & ~WDATA[status_indicator_pkg::IRQ_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_status <= status_indicator_pkg::IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_mask <= status_indicator_pkg::IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask <= WDATA[status_indicator_pkg::IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe only

  logic [15:0] read_value;

  always_comb begin
    unique case (ADDR)
      status_indicator_pkg::ADDR_LEVEL_STATUS: begin
        read_value = LEVEL_STATUS;
      end
      status_indicator_pkg::ADDR_PROC_STATUS: begin
        read_value = PROC_STATUS;
      end
      status_indicator_pkg::ADDR_BYTE_DIRECT: begin
        read_value = {8'h00, status_byte_direct};
      end
      status_indicator_pkg::ADDR_BYTE_CYCLE: begin
        read_value = {8'h00, status_byte_cycle};
      end
      status_indicator_pkg::ADDR_COND_CODE: begin
        read_value = {11'h000, last_source, last_cc};
      end
      status_indicator_pkg::ADDR_IRQ_STATUS: begin
        read_value = {11'h000, irq_status};
      end
      status_indicator_pkg::ADDR_IRQ_MASK: begin
        read_value = {11'h000, irq_mask};
      end
      status_indicator_pkg::ADDR_RESULT_LOW: begin
        read_value = ALU_RESULT[15:0];
      end
      status_indicator_pkg::ADDR_RESULT_HIGH: begin
        read_value = ALU_RESULT[31:16];
      end
      default: begin
        read_value = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= read_value;
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ==== status_indicator_pkg.sv ====
// Notes on behaviour
// R01: Add or subtract sets overflow when the carries into and out of the sign bit differ.
// R02: Add or subtract clears overflow when the carries into and out of the sign bit agree.
// R03: Subtract adds minuend, inverted subtrahend and a constant one; carries come from that.
// R04: On subtract the carry indicator is the inverse of the complement-add carry out (a borrow).
// R05: An I/O operate completion puts its three-bit code into even, carry, overflow, even highest.
// R06: I/O codes 0-7: absent, busy, reset busy, reject, intervene, data check, ctl busy, good.
// R07: Interrupt codes: 0 controller end, 1 program int, 2 exception, 3 device end, 4-7 attention.
// R08: A three-bit register select field picks general register 0 to 7 by its binary value.
// R09: A two-bit base register field picks only registers 0 to 3, never 4 to 7.
// R10: The interrupt status byte has status available in bit 0 and delayed reject in bit 1.
// R11: Cycle-steal status bytes hold length, block, data, address, zero, interface in bits 2-7.
// R12: Level status holds indicators in bits 0-4 and state in bits 8-11, other bits zero.
// R13: The status word flags checks at bits 0,1,2,4,6,8,10,11,12,13,15, other bits zero.
// R14: The sign position is the top bit of the operand width in use: byte, word or double word.
`default_nettype none
package status_indicator_pkg;

  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 16;
  localparam int OPND_WIDTH = 32;

  localparam logic [3:0] ADDR_LEVEL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_PROC_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_BYTE_DIRECT  = 4'h2;
  localparam logic [3:0] ADDR_BYTE_CYCLE   = 4'h3;
  localparam logic [3:0] ADDR_COND_CODE    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h6;
  localparam logic [3:0] ADDR_RESULT_LOW   = 4'h7;
  localparam logic [3:0] ADDR_RESULT_HIGH  = 4'h8;

  localparam int LSR_EVEN       = 0;
  localparam int LSR_CARRY      = 1;
  localparam int LSR_OVERFLOW   = 2;
  localparam int LSR_NEGATIVE   = 3;
  localparam int LSR_ZERO       = 4;
  localparam int LSR_SUPERVISOR = 8;
  localparam int LSR_IN_PROCESS = 9;
  localparam int LSR_TRACE      = 10;
  localparam int LSR_SUMMARY    = 11;
  localparam logic [15:0] LSR_IMPL_MASK = 16'h0F1F;
  localparam logic [15:0] LSR_RESET     = 16'h0000;

  localparam logic [15:0] PSW_IMPL_MASK = 16'hBD57;
  localparam logic [15:0] PSW_RESET     = 16'h0000;

  localparam int BYTE_CS_ZERO_BIT = 6;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  localparam int IRQ_WIDTH        = 5;
  localparam int IRQ_OVERFLOW     = 0;
  localparam int IRQ_IO_DONE      = 1;
  localparam int IRQ_IO_FAIL      = 2;
  localparam int IRQ_INT_ACCEPT   = 3;
  localparam int IRQ_PSW_CHECK    = 4;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  localparam logic [2:0] CC_SATISFACTORY = 3'h7;

  typedef enum logic [1:0] {
    WIDTH_BYTE   = 2'b00,
    WIDTH_WORD   = 2'b01,
    WIDTH_DOUBLE = 2'b10
  } operand_width_type;

  localparam int SIGN_BYTE   = 7;
  localparam int SIGN_WORD   = 15;
  localparam int SIGN_DOUBLE = 31;

  typedef enum logic [1:0] {
    CC_SOURCE_NONE      = 2'b00,
    CC_SOURCE_IO        = 2'b01,
    CC_SOURCE_INTERRUPT = 2'b10
  } cc_source_type;

  typedef struct packed {
    logic              valid;
    logic              subtract;
    operand_width_type width;
    logic [31:0]       operand_a;
    logic [31:0]       operand_b;
  } alu_request_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] condition_code;
  } io_completion_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] condition_code;
    logic       cycle_steal;
    logic [7:0] status_byte;
  } interrupt_accept_type;

  typedef struct packed {
    logic       valid;
    logic       two_bit;
    logic [2:0] field;
  } register_select_type;

endpackage
`default_nettype wire

// ==== status_indicator_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_indicator_assertions (
  input wire logic                                       CLK_SYS,
  input wire logic                                       RESET,
  input wire logic                                       RD,
  input wire logic [15:0]                                RDATA,
  input wire status_indicator_pkg::alu_request_type      ALU_REQ,
  input wire logic [31:0]                                ALU_RESULT,
  input wire logic                                       ALU_DONE,
  input wire status_indicator_pkg::io_completion_type    IO_DONE,
  input wire status_indicator_pkg::register_select_type  REG_SELECT,
  input wire logic [7:0]                                 REG_ENABLE,
  input wire logic [15:0]                                LEVEL_STATUS,
  input wire logic [15:0]                                PROC_STATUS
);
  ////////////////////////////////////////////////////////////
  // Word-width reference adder for the sign carries
  logic        word_op;
  logic [15:0] addend;
  logic [15:0] low_sum;
  logic [16:0] full_sum;
  logic        ovf_word;
  logic        carry_word;
  logic [15:0] res_word;
  logic [2:0]  io_cc_rev;
  logic [7:0]  sel3;
  logic [7:0]  sel2;
  assign word_op    = ALU_REQ.valid && ALU_REQ.width == status_indicator_pkg::WIDTH_WORD;
  assign addend     = ALU_REQ.subtract ? ~ALU_REQ.operand_b[15:0] : ALU_REQ.operand_b[15:0];
  assign low_sum    = {1'b0, ALU_REQ.operand_a[14:0]} + {1'b0, addend[14:0]}
                      + 16'(ALU_REQ.subtract);
  assign full_sum   = {1'b0, ALU_REQ.operand_a[15:0]} + {1'b0, addend} + 17'(ALU_REQ.subtract);
  assign ovf_word   = low_sum[15] ^ full_sum[16];
  assign carry_word = full_sum[16] ^ ALU_REQ.subtract;
  assign res_word   = full_sum[15:0];
  assign io_cc_rev  = {IO_DONE.condition_code[0], IO_DONE.condition_code[1],
                       IO_DONE.condition_code[2]};
  assign sel3       = 8'h01 << REG_SELECT.field;
  assign sel2       = 8'h01 << REG_SELECT.field[1:0];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////
  property p_ovf_set;
    word_op && ovf_word |=> LEVEL_STATUS[2];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not set");
  property p_ovf_clear;
    word_op && !ovf_word |=> !LEVEL_STATUS[2];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow not cleared");
  property p_sub_carry;
    word_op |=> ALU_DONE && LEVEL_STATUS[1] == $past(carry_word)
      && ALU_RESULT == {16'h0000, $past(res_word)};
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("alu result or carry wrong");
  property p_io_cc;
    IO_DONE.valid && !ALU_REQ.valid |=> LEVEL_STATUS[2:0] == $past(io_cc_rev);
  endproperty
  a_io_cc: assert property (p_io_cc)
    else $error("condition code bits wrong");
  property p_sel3;
    REG_SELECT.valid && !REG_SELECT.two_bit |=> REG_ENABLE == $past(sel3);
  endproperty
  a_sel3: assert property (p_sel3)
    else $error("three-bit select wrong");
  property p_sel2;
    REG_SELECT.valid && REG_SELECT.two_bit |=> REG_ENABLE == $past(sel2);
  endproperty
  a_sel2: assert property (p_sel2)
    else $error("two-bit select wrong");
  property p_lsr_zero;
    (LEVEL_STATUS & 16'hF0E0) == 16'h0000;
  endproperty
  a_lsr_zero: assert property (p_lsr_zero)
    else $error("level status unused bit set");
  property p_psw_zero;
    (PROC_STATUS & 16'h42A8) == 16'h0000;
  endproperty
  a_psw_zero: assert property (p_psw_zero)
    else $error("status word unused bit set");
  property p_rd_idle;
    !RD |=> RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ==== io_channel_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module io_channel_model (
  input  wire logic                                   clk,
  output var  status_indicator_pkg::io_completion_type    io_done,
  output var  status_indicator_pkg::interrupt_accept_type int_accept
);
  initial begin
    io_done    = '0;
    int_accept = '0;
  end
  ////////////////////////////////////////////////////////////
  // Released fields carry the inverse so stale values never match
  task automatic io_complete(input logic [2:0] cc);
    @(posedge clk);
    io_done <= '{1'b1, cc};
    @(posedge clk);
    io_done <= '{1'b0, ~cc};
  endtask
  task automatic accept_interrupt(input logic [2:0] cc, input logic cs, input logic [7:0] sb);
    @(posedge clk);
    int_accept <= '{1'b1, cc, cs, cs ? (sb & 8'hBF) : sb};
    @(posedge clk);
    int_accept <= '{1'b0, ~cc, ~cs, ~sb};
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                                       clk_sys = 1'b0;
  logic                                       reset = 1'b1;
  logic [3:0]                                 addr = 4'h0;
  logic [15:0]                                wdata = 16'h0000;
  logic                                       wr = 1'b0;
  logic                                       rd = 1'b0;
  logic [15:0]                                psw_set = 16'h0000;
  status_indicator_pkg::alu_request_type      alu_req = '0;
  status_indicator_pkg::register_select_type  reg_select = '0;
  status_indicator_pkg::io_completion_type    io_done;
  status_indicator_pkg::interrupt_accept_type int_accept;
  logic [15:0]                                rdata;
  logic                                       irq;
  logic [31:0]                                alu_result;
  logic                                       alu_done;
  logic [7:0]                                 reg_enable;
  logic [15:0]                                level_status;
  logic [15:0]                                proc_status;
  int                                         n_errors = 0;
  int                                         comparisons = 0;

  always #25 clk_sys = ~clk_sys;

  status_indicator_logic i_dut (.CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .ALU_REQ(alu_req), .ALU_RESULT(alu_result),
    .ALU_DONE(alu_done), .IO_DONE(io_done), .INT_ACCEPT(int_accept), .PSW_SET(psw_set),
    .REG_SELECT(reg_select), .REG_ENABLE(reg_enable), .LEVEL_STATUS(level_status),
    .PROC_STATUS(proc_status));
  io_channel_model i_chan (.clk(clk_sys), .io_done(io_done), .int_accept(int_accept));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk({16'h0000, rdata}, {16'h0000, exp}, what);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_map();
    for (int a = 0; a < 10; a++) rchk(4'(a), 16'h0000, "reset value");
    bus_write(4'h0, 16'hFFFF);
    rchk(4'h0, 16'h0F1F, "level status bits");
    bus_write(4'h2, 16'hFFFF);
    rchk(4'h2, 16'h0000, "read-only byte");
    bus_write(4'hF, 16'hFFFF);
    rchk(4'hF, 16'h0000, "unmapped");
    bus_write(4'h0, 16'h0000);
    $display("t_map done");
  endtask
  task automatic t_alu();
    logic [1:0]  w [9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
    logic        s [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [31:0] a [9] = '{32'h7FFF, 32'h8000, 32'h7, 32'h0, 32'h8000, 32'hFFFF,
                           32'h1234567F, 32'h80, 32'h7FFFFFFF};
    logic [31:0] b [9] = '{32'h1, 32'h8000, 32'h2, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1};
    logic [31:0] r [9] = '{32'h8000, 32'h0, 32'h5, 32'hFFFF, 32'h7FFF, 32'h0, 32'h80, 32'h7F,
                           32'h80000000};
    logic [4:0]  f [9] = '{5'h0D, 5'h17, 5'h00, 5'h0A, 5'h04, 5'h13, 5'h0D, 5'h04, 5'h0D};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      alu_req <= '{1'b1, s[i], status_indicator_pkg::operand_width_type'(w[i]), a[i], b[i]};
      @(posedge clk_sys);
      alu_req.valid <= 1'b0;
      #1;
      chk(alu_result, r[i], "alu result");
      chk({27'h0, level_status[4:0]}, {27'h0, f[i]}, "alu flags");
      chk({31'h0, alu_done}, 32'h1, "alu done");
    end
    rchk(4'h7, 16'h0000, "result low");
    rchk(4'h8, 16'h8000, "result high");
    $display("t_alu done");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      i_chan.io_complete(3'(c));
      #1;
      chk({29'h0, level_status[2:0]}, {29'h0, c[0], c[1], c[2]}, "io code");
      rchk(4'h4, 16'h0008 + 16'(c), "io source");
      i_chan.accept_interrupt(3'(c), c[0], 8'hFF);
      #1;
      chk({29'h0, level_status[2:0]}, {29'h0, c[0], c[1], c[2]}, "int code");
      rchk(4'h4, 16'h0010 + 16'(c), "int source");
      rchk(c[0] ? 4'h3 : 4'h2, c[0] ? 16'h00BF : 16'h00FF, "status byte");
    end
    $display("t_codes done");
  endtask
  task automatic t_select();
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      reg_select <= '{1'b1, k[3], k[2:0]};
      @(posedge clk_sys);
      reg_select.valid <= 1'b0;
      #1;
      chk({24'h0, reg_enable}, {24'h0, 8'h01 << (k[3] ? k[1:0] : k[2:0])}, "select");
    end
    @(posedge clk_sys);
    #1;
    chk({24'h0, reg_enable}, 32'h0, "select idle");
    $display("t_select done");
  endtask
  task automatic t_irq();
    rchk(4'h5, 16'h000F, "irq events");
    bus_write(4'h5, 16'h001F);
    bus_write(4'h6, 16'h0000);
    @(posedge clk_sys);
    psw_set <= 16'hFFFF;
    @(posedge clk_sys);
    psw_set <= 16'h0000;
    rchk(4'h1, 16'hBD57, "status word");
    chk({16'h0000, proc_status}, 32'h0000BD57, "status word port");
    rchk(4'h5, 16'h0010, "irq status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus_write(4'h6, 16'h0010);
    rchk(4'h6, 16'h0010, "irq mask");
    chk({31'h0, irq}, 32'h1, "irq raised");
    bus_write(4'h1, 16'hBD57);
    bus_write(4'h5, 16'h001F);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rchk(4'h1, 16'h0000, "status word cleared");
    $display("t_irq done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_map();
    t_alu();
    t_codes();
    t_select();
    t_irq();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
bind status_indicator_logic status_indicator_assertions i_chk (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .RD(RD), .RDATA(RDATA), .ALU_REQ(ALU_REQ), .ALU_RESULT(ALU_RESULT),
  .ALU_DONE(ALU_DONE), .IO_DONE(IO_DONE), .REG_SELECT(REG_SELECT), .REG_ENABLE(REG_ENABLE),
  .LEVEL_STATUS(LEVEL_STATUS), .PROC_STATUS(PROC_STATUS));
`default_nettype wire
